// ### octal_latch_defs.vh
`ifndef OCTAL_LATCH_DEFS_VH
`define OCTAL_LATCH_DEFS_VH

`define CHAN_COUNT        8
`define CHAN_TOP          3'h7
`define CLK_SYS_MHZ       100
`define INHIBIT_US        160
`define INHIBIT_CYCLES    (`INHIBIT_US * `CLK_SYS_MHZ)
`define CNT_W             15
`define LATCH_RESET       8'hff
`define SHIFT_RESET       8'h00
`define FIFO_DEPTH        4
`define FIFO_PTR_W        2
`define SYNC_W            11
`define SYNC_RESET        11'h001
`define SYNC_SEL          0
`define SYNC_SCLK         1
`define SYNC_SDI          2
`define SYNC_SENSE        3
`define FRAME_RESET       8'h00

`endif

// ### frame_fifo.v
`timescale 1ns/1ns
`default_nettype none

// small first-in first-out buffer with valid/ready on both sides
module frame_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0]   count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != DEPTH);
  assign out_valid = (count != 0);
  assign out_data  = mem[rd_ptr];

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count  <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // frame_fifo

`default_nettype wire

// ### octal_serial_output_latch_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "octal_latch_defs.vh"

// What this block does
// - selected only while select line is low
// - serial output driven only while selected
// - select falling loads sensed output levels
// - select rising copies shift register to latch
// - next bit out after serial clock rising
// - serial input shifted in on clock falling
// - highest channel diagnostic out first rising edge
// - zero turns channel on, one off
// - eight bit shift register holds frame
// - unlimited clocks pass through for daisy chain
// - one latch bit per channel
// - fault on active channel sets its bit
// - reset sets whole latch at once
// - inhibit timer after select rising blocks faults
// - serial clock ignored while deselected
// - reset clears outputs and shift register, sets latch
module octal_serial_output_latch_ctrl #(
  parameter INHIBIT_CYCLES = `INHIBIT_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       sel_n,
  input  wire       sclk,
  input  wire       sdi,
  input  wire [7:0] out_sense,
  output reg        sdo,
  output reg        sdo_oe,
  output reg  [7:0] chan_ctrl,
  output reg  [7:0] chan_on,
  output reg        inhibit_active,
  output reg  [7:0] frame_data,
  output reg        frame_valid,
  input  wire       frame_ready,
  output reg        frame_overrun
);

  // -------------------------------------------------------------------
  // link phase states
  // -------------------------------------------------------------------
  // idle until select falls, load for one cycle, shift, then commit
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_LOAD   = 2'b01;
  localparam [1:0] ST_SHIFT  = 2'b10;
  localparam [1:0] ST_COMMIT = 2'b11;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // level went from low to high between two samples
  function rise_of;
    input prev;
    input curr;
    begin
      rise_of = !prev && curr;
    end
  endfunction

  // level went from high to low between two samples
  function fall_of;
    input prev;
    input curr;
    begin
      fall_of = prev && !curr;
    end
  endfunction

  // a channel programmed on that still reads high is overloaded
  function fault_of;
    input ctrl_bit;
    input sense_bit;
    begin
      fault_of = !ctrl_bit && sense_bit;
    end
  endfunction

  // counter has run out
  function cnt_zero;
    input [`CNT_W-1:0] value;
    begin
      cnt_zero = (value == {`CNT_W{1'b0}});
    end
  endfunction

  // -------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------
  // every serial and sense pin crosses two flip-flops before any logic reads it
  wire [`SYNC_W-1:0] async_in   = {out_sense, sdi, sclk, sel_n};
  wire [`SYNC_W-1:0] sync_reset = `SYNC_RESET;
  wire [`SYNC_W-1:0] sync_out;
  genvar             j;

  generate
    for (j = 0; j < `SYNC_W; j = j + 1) begin : g_sync
      reg first_q;
      reg second_q;
      always @(posedge clk_sys) begin
        if (rst) begin
          first_q  <= sync_reset[j];
          second_q <= sync_reset[j];
        end else begin
          first_q  <= async_in[j];
          second_q <= first_q;
        end
      end
      assign sync_out[j] = second_q;
    end
  endgenerate

  wire       sel_n_s = sync_out[`SYNC_SEL];
  wire       sclk_s  = sync_out[`SYNC_SCLK];
  wire       sdi_s   = sync_out[`SYNC_SDI];
  wire [7:0] sense_s = sync_out[`SYNC_SENSE +: 8];
  reg        sel_n_d;
  reg        sclk_d;

  // one more stage on select and clock to see their edges
  always @(posedge clk_sys) begin
    if (rst) begin
      sel_n_d <= 1'b1;
      sclk_d  <= 1'b0;
    end else begin
      sel_n_d <= sel_n_s;
      sclk_d  <= sclk_s;
    end
  end

  // -------------------------------------------------------------------
  // edge detection
  // -------------------------------------------------------------------
  reg  [1:0] link_state;
  reg  [1:0] next_link_state;

  wire       selected  = !sel_n_s;
  wire       sel_fall  = fall_of(sel_n_d, sel_n_s);
  wire       sel_rise  = rise_of(sel_n_d, sel_n_s);
  // serial clock edges count only once the link is past its idle phase
  wire       link_open = selected && (link_state == ST_LOAD || link_state == ST_SHIFT);
  wire       sck_rise  = link_open && rise_of(sclk_d, sclk_s);
  wire       sck_fall  = link_open && fall_of(sclk_d, sclk_s);

  // -------------------------------------------------------------------
  // link phase tracking
  // -------------------------------------------------------------------
  always @* begin
    next_link_state = link_state;
    case (link_state)
      ST_IDLE: begin
        if (sel_fall) begin
          next_link_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (selected) begin
          next_link_state = ST_SHIFT;
        end else begin
          next_link_state = ST_COMMIT;
        end
      end
      ST_SHIFT: begin
        if (sel_rise) begin
          next_link_state = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        if (sel_fall) begin
          next_link_state = ST_LOAD;
        end else begin
          next_link_state = ST_IDLE;
        end
      end
      default: begin
        next_link_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      link_state <= ST_IDLE;
    end else begin
      link_state <= next_link_state;
    end
  end

  // -------------------------------------------------------------------
  // shift register
  // -------------------------------------------------------------------
  reg [7:0] shift;
  reg [7:0] next_shift;

  // sense levels jam in at select fall, serial bits follow
  always @* begin
    next_shift = shift;
    if (sel_fall) begin
      next_shift = sense_s;
    end else if (sck_fall) begin
      next_shift = {shift[6:0], sdi_s};
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      shift <= `SHIFT_RESET;
    end else begin
      shift <= next_shift;
    end
  end

  // -------------------------------------------------------------------
  // serial output
  // -------------------------------------------------------------------
  // msb shown after each rising clock edge
  reg next_sdo;

  always @* begin
    next_sdo = sdo;
    if (sck_rise) begin
      next_sdo = shift[`CHAN_TOP];
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= next_sdo;
      sdo_oe <= selected;
    end
  end

  // -------------------------------------------------------------------
  // inhibit timer
  // -------------------------------------------------------------------
  reg  [`CNT_W-1:0] inhibit_cnt;
  reg  [`CNT_W-1:0] next_inhibit_cnt;
  wire              inhibit = !cnt_zero(inhibit_cnt);

  // loaded at every commit so inrush after switch-on is not taken as a fault
  always @* begin
    next_inhibit_cnt = inhibit_cnt;
    if (sel_rise) begin
      next_inhibit_cnt = INHIBIT_CYCLES[`CNT_W-1:0];
    end else if (inhibit) begin
      next_inhibit_cnt = inhibit_cnt - 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      inhibit_cnt    <= {`CNT_W{1'b0}};
      inhibit_active <= 1'b0;
    end else begin
      inhibit_cnt    <= next_inhibit_cnt;
      inhibit_active <= !cnt_zero(next_inhibit_cnt);
    end
  end

  // -------------------------------------------------------------------
  // output control latch, one bit per channel
  // -------------------------------------------------------------------
  wire [7:0] next_ctrl;
  genvar     g;

  generate
    for (g = 0; g < `CHAN_COUNT; g = g + 1) begin : g_chan
      // an overload only counts once the inhibit time is over
      wire fault_hit = !inhibit && fault_of(chan_ctrl[g], sense_s[g]);
      assign next_ctrl[g] = sel_rise ? shift[g] : (fault_hit | chan_ctrl[g]);
    end
  endgenerate

  // drive outputs are the inverse of the stored bits
  always @(posedge clk_sys) begin
    if (rst) begin
      chan_ctrl <= `LATCH_RESET;
      chan_on   <= ~`LATCH_RESET;
    end else begin
      chan_ctrl <= next_ctrl;
      chan_on   <= ~next_ctrl;
    end
  end

  // -------------------------------------------------------------------
  // record of committed frames through a small buffer
  // -------------------------------------------------------------------
  wire       fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  // the output stage refills as soon as it is empty or being taken
  wire       fifo_pop = fifo_out_valid && (!frame_valid || frame_ready);
  reg  [7:0] next_frame_data;
  reg        next_frame_valid;
  reg        next_frame_overrun;

  frame_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .PTR_W (`FIFO_PTR_W)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (shift),
    .in_valid  (sel_rise),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  always @* begin
    next_frame_data    = frame_data;
    next_frame_valid   = frame_valid;
    next_frame_overrun = frame_overrun;
    if (fifo_pop) begin
      next_frame_data  = fifo_out_data;
      next_frame_valid = 1'b1;
    end else if (frame_ready) begin
      next_frame_valid = 1'b0;
    end
    // sticky: a frame arrived while the buffer was full
    if (sel_rise && !fifo_in_ready) begin
      next_frame_overrun = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      frame_data    <= `FRAME_RESET;
      frame_valid   <= 1'b0;
      frame_overrun <= 1'b0;
    end else begin
      frame_data    <= next_frame_data;
      frame_valid   <= next_frame_valid;
      frame_overrun <= next_frame_overrun;
    end
  end

endmodule // octal_serial_output_latch_ctrl

`default_nettype wire

// ### octal_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module octal_ctrl_checker #(
  parameter INHIBIT_CYCLES = 50
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       sel_n,
  input wire logic [7:0] out_sense,
  input wire logic       sdo_oe,
  input wire logic [7:0] chan_ctrl,
  input wire logic [7:0] chan_on,
  input wire logic       inhibit_active,
  input wire logic [7:0] frame_data,
  input wire logic       frame_valid,
  input wire logic       frame_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_oe_off: assert property (sel_n[*6] |-> !sdo_oe)
    else $error("sdo enabled while deselected");
  chk_oe_on: assert property ((!sel_n)[*6] |-> sdo_oe)
    else $error("sdo not enabled while selected");
  chk_on_inv: assert property (chan_on == ~chan_ctrl)
    else $error("drive not inverse of control");
  chk_rst_val: assert property ($fell(rst) |-> chan_ctrl == 8'hff && !sdo_oe)
    else $error("reset values wrong");
  chk_ctrl_src: assert property ($changed(chan_ctrl) |->
    inhibit_active || ($past(chan_ctrl) & ~chan_ctrl) == 8'h00)
    else $error("channel turned on without commit");
  chk_inh_min: assert property ($rose(inhibit_active) |-> inhibit_active[*8])
    else $error("inhibit too short");
  chk_fault_off: assert property (not ((!inhibit_active
    && (out_sense & chan_on) != 8'h00)[*6]))
    else $error("faulted channel kept on");
  chk_frm_hold: assert property (frame_valid && !frame_ready
    |=> frame_valid && $stable(frame_data))
    else $error("frame dropped before taken");
endmodule // octal_ctrl_checker
bind octal_serial_output_latch_ctrl octal_ctrl_checker #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) chk_inst (
  .clk_sys(clk_sys), .rst(rst), .sel_n(sel_n), .out_sense(out_sense), .sdo_oe(sdo_oe),
  .chan_ctrl(chan_ctrl), .chan_on(chan_on), .inhibit_active(inhibit_active),
  .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready));
`default_nettype wire

// ### host_spi_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  input  wire logic clk_sys,
  input  wire logic so_line,
  output var  logic sel_n,
  output var  logic sclk,
  output var  logic sdi
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // msb first; serial out read late in the high phase
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] got);
    got = 16'h0000;
    @(negedge clk_sys);
    sel_n = 1'b0;
    #2;
    for (int i = n - 1; i >= 0; i--) begin
      #31 sdi = d[i];
      #31 sclk = 1'b1;
      #63 got = {got[14:0], so_line};
      sclk = 1'b0;
    end
    #62 sel_n = 1'b1;
    #40 sdi = ~sdi;
  endtask
endmodule // host_spi_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  out_sense = 8'h00;
  logic        frame_ready = 1'b1;
  wire         sel_n, sclk, sdi, sdo, sdo_oe, inhibit_active, frame_valid, frame_overrun;
  wire  [7:0]  chan_ctrl, chan_on, frame_data;
  wire         so_line = sdo_oe ? sdo : 1'bz;
  int          err_total = 0;
  int          n_tests = 0;
  int          k;
  logic [7:0]  exp_q[$];
  logic [15:0] got;
  logic [7:0]  d;
  logic [7:0]  s;
  always #5 clk_sys = ~clk_sys;
  octal_serial_output_latch_ctrl #(.INHIBIT_CYCLES(50)) octal_serial_output_latch_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .out_sense(out_sense),
    .sdo(sdo), .sdo_oe(sdo_oe), .chan_ctrl(chan_ctrl), .chan_on(chan_on),
    .inhibit_active(inhibit_active), .frame_data(frame_data), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_overrun(frame_overrun));
  host_spi_model host_spi_model_inst (.clk_sys(clk_sys), .so_line(so_line), .sel_n(sel_n),
    .sclk(sclk), .sdi(sdi));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (!rst && frame_valid && frame_ready) begin
      if (exp_q.size() > 0)
        check(frame_data, exp_q.pop_front());
      else begin
        err_total++;
        $display("[ERR] %0t unexpected frame %h", $time, frame_data);
      end
    end
  task automatic frame(input logic [15:0] dd, input int n);
    if (exp_q.size() < 5)
      exp_q.push_back(dd[7:0]);
    @(negedge clk_sys);
    s = 8'($urandom);
    out_sense = s;
    host_spi_model_inst.xfer(dd, n, got);
    check(got[n-1 -: 8], s);
    if (n == 16)
      check(got[7:0], dd[15:8]);
    repeat (8) @(negedge clk_sys);
    out_sense = dd[7:0];
    check(chan_ctrl, dd[7:0]);
    check(chan_on, ~dd[7:0]);
  endtask
  initial begin
    k = $urandom(4449);
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    check(chan_ctrl, 8'hff);
    check({7'h00, sdo_oe}, 8'h00);
    repeat (4) @(negedge clk_sys);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
      frame({8'h00, 8'($urandom)}, 8);
    frame(16'($urandom), 16);
    $display("frame test done");
    k = $urandom_range(7, 0);
    d = 8'($urandom) & ~(8'h01 << k);
    frame({8'h00, d}, 8);
    out_sense[k] = 1'b1;
    repeat (20) @(negedge clk_sys);
    check(chan_ctrl, d);
    for (int i = 0; i < 200 && inhibit_active !== 1'b0; i++)
      @(negedge clk_sys);
    check({7'h00, inhibit_active}, 8'h00);
    repeat (8) @(negedge clk_sys);
    check(chan_ctrl, d | (8'h01 << k));
    $display("fault test done");
    frame_ready = 1'b0;
    for (int i = 0; i < 6; i++)
      frame({8'h00, 8'($urandom)}, 8);
    check({7'h00, frame_overrun}, 8'h01);
    frame_ready = 1'b1;
    repeat (20) @(negedge clk_sys);
    check(8'(exp_q.size()), 8'h00);
    $display("buffer test done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
